// >>> rtl/mdc_pkg.sv
// Constants shared by the datapath configuration bank and its serial link.
// Assumes a 125 MHz core clock and a host that samples the serial port slowly.
package mdc_pkg;

    // Register word addresses as seen on the serial port
    localparam logic [11:0] MDC_ADDR_CONFIG     = 12'h060;
    localparam logic [11:0] MDC_ADDR_C_IRMS_LNG = 12'h6B7;
    localparam logic [11:0] MDC_ADDR_C_VRMS_LNG = 12'h6B8;
    localparam logic [11:0] MDC_ADDR_N_WAVE     = 12'h6B9;
    localparam logic [11:0] MDC_ADDR_N_IRMS     = 12'h6BA;
    localparam logic [11:0] MDC_ADDR_N_IRMS_HLF = 12'h6BB;
    localparam logic [11:0] MDC_ADDR_N_IRMS_LNG = 12'h6BC;
    localparam int          MDC_NUM_COPIES      = 6;

    // Field positions in the configuration word
    localparam int MDC_BIT_REACT_LPF_BYP = 13;
    localparam int MDC_BIT_ACT_LPF_BYP   = 12;
    localparam int MDC_BIT_NEUT_INTEG    = 11;
    localparam int MDC_BIT_NOM_V_C       = 10;
    localparam int MDC_BIT_NOM_V_B       = 9;
    localparam int MDC_BIT_NOM_V_A       = 8;
    localparam int MDC_BIT_RMS_SEL       = 7;
    localparam int MDC_BIT_ZX_SEL        = 6;
    localparam int MDC_BIT_PHASE_INTEG   = 5;
    localparam int MDC_BIT_MULTIPOINT    = 4;
    localparam int MDC_BIT_HPF_BYP       = 3;
    localparam int MDC_BIT_SUM_LO        = 0;

    // Writable bits, reset values
    localparam logic [31:0] MDC_CONFIG_WMASK = 32'h0000_3FFB;
    localparam logic [31:0] MDC_CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] MDC_COPY_RESET   = 32'h0000_0000;

    // Summed-current formula codes
    typedef enum logic [1:0] {
        MDC_SUM_PHASES   = 2'h0,
        MDC_SUM_PLUS_N   = 2'h1,
        MDC_SUM_MINUS_N  = 2'h2,
        MDC_SUM_PHASES_B = 2'h3
    } mdc_sum_t;

    // Multipoint compensation regions
    localparam int          MDC_MT_REGIONS  = 6;
    localparam logic [2:0]  MDC_MT_TOP      = 3'h5;

    // Serial framing
    localparam logic [4:0]  MDC_CMD_LAST    = 5'h0F;
    localparam logic [4:0]  MDC_WORD_LAST   = 5'h1F;

endpackage : mdc_pkg

// >>> rtl/mdc_spi_link.sv
// Serial port slave: command word, then 32-bit data words with auto-increment.
// Assumes pins synchronous to i_clock and a serial clock half-period of >= 4 cycles.
`timescale 1ns/10ps
module mdc_spi_link
    import mdc_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        i_spi_sclk,
    input  wire logic        i_spi_cs_n,
    input  wire logic        i_spi_mosi,
    output logic             o_spi_miso,
    output logic [11:0]      o_addr,
    output logic             o_wr,
    output logic [31:0]      o_wdata,
    output logic             o_rd,
    input  wire logic [31:0] i_rdata
);

    logic        sclk_q;
    logic [4:0]  cnt_q;
    logic        in_data_q;
    logic        is_read_q;
    logic        load_q;
    logic [31:0] in_sh_q;
    logic [31:0] out_sh_q;
    logic        rise;
    logic        fall;

    // Edge detection on the sampled serial clock
    assign rise = ~i_spi_cs_n & i_spi_sclk & ~sclk_q;
    assign fall = ~i_spi_cs_n & ~i_spi_sclk & sclk_q;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= i_spi_sclk;
        end
    end

    // Receive side: command decode, write strobes, burst addressing
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q     <= 5'h00;
            in_data_q <= 1'b0;
            is_read_q <= 1'b0;
            in_sh_q   <= 32'h0000_0000;
            o_addr    <= 12'h000;
            o_wr      <= 1'b0;
            o_rd      <= 1'b0;
            o_wdata   <= 32'h0000_0000;
        end else begin
            o_wr <= 1'b0;
            o_rd <= 1'b0;
            if (o_wr) begin
                o_addr <= o_addr + 12'h001;       // Next word of a write burst
            end
            if (i_spi_cs_n) begin
                cnt_q     <= 5'h00;
                in_data_q <= 1'b0;
            end else if (rise) begin
                in_sh_q <= {in_sh_q[30:0], i_spi_mosi};
                cnt_q   <= cnt_q + 5'h01;
                if (!in_data_q && cnt_q == MDC_CMD_LAST) begin
                    o_addr    <= in_sh_q[14:3];
                    is_read_q <= in_sh_q[2];
                    o_rd      <= in_sh_q[2];
                    in_data_q <= 1'b1;
                    cnt_q     <= 5'h00;
                end else if (in_data_q && cnt_q == MDC_WORD_LAST) begin
                    cnt_q <= 5'h00;
                    if (is_read_q) begin
                        o_addr <= o_addr + 12'h001;   // Burst read walks upward
                        o_rd   <= 1'b1;
                    end else begin
                        o_wr    <= 1'b1;
                        o_wdata <= {in_sh_q[30:0], i_spi_mosi};
                    end
                end
            end
        end
    end

    // Transmit side: load fetched word on the next falling edge
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            load_q     <= 1'b0;
            out_sh_q   <= 32'h0000_0000;
            o_spi_miso <= 1'b0;
        end else begin
            if (o_rd) begin
                load_q <= 1'b1;
            end else if (i_spi_cs_n) begin
                load_q <= 1'b0;
            end
            if (i_spi_cs_n) begin
                o_spi_miso <= 1'b0;
            end else if (fall) begin
                if (load_q && !o_rd) begin
                    o_spi_miso <= i_rdata[31];
                    out_sh_q   <= {i_rdata[30:0], 1'b0};
                    load_q     <= 1'b0;
                end else if (in_data_q && is_read_q) begin
                    o_spi_miso <= out_sh_q[31];
                    out_sh_q   <= {out_sh_q[30:0], 1'b0};
                end
            end
        end
    end

endmodule : mdc_spi_link

// >>> rtl/mdc_top.sv
// Datapath configuration word, phase-ordered result copies and the selection
// logic that the configuration steers. Assumes the core feeds samples and results.
`timescale 1ns/10ps
module mdc_top
    import mdc_pkg::*;
#(
    parameter int DW = 32
)(
    input  wire logic                i_clock,
    input  wire logic                i_nrst,
    input  wire logic                i_spi_sclk,
    input  wire logic                i_spi_cs_n,
    input  wire logic                i_spi_mosi,
    output logic                     o_spi_miso,
    input  wire logic [DW-1:0]       i_phase_a_current_waveform,
    input  wire logic [DW-1:0]       i_phase_b_current_waveform,
    input  wire logic [DW-1:0]       i_phase_c_current_waveform,
    input  wire logic [DW-1:0]       i_neutral_current_waveform,
    input  wire logic [DW-1:0]       i_rms_filtered_sample,
    input  wire logic [DW-1:0]       i_rms_raw_sample,
    input  wire logic [DW-1:0]       i_zero_cross_after_filters,
    input  wire logic [DW-1:0]       i_zero_cross_before_filters,
    input  wire logic [DW-1:0]       i_nominal_voltage_value,
    input  wire logic [2:0][DW-1:0]  i_phase_voltage_rms,
    input  wire logic [2:0][DW-1:0]  i_phase_current_rms,
    input  wire logic [4:0][DW-1:0]  i_multipoint_low_threshold,
    input  wire logic [4:0][DW-1:0]  i_multipoint_high_threshold,
    input  wire logic                i_result_update,
    input  wire logic [5:0][31:0]    i_result_copy_value,
    output logic                     o_reactive_lowpass_bypass,
    output logic                     o_active_lowpass_bypass,
    output logic                     o_neutral_integrator_on,
    output logic                     o_phase_integrator_on,
    output logic                     o_multipoint_comp_on,
    output logic                     o_highpass_bypass_all,
    output logic [DW-1:0]            o_rms_input,
    output logic [DW-1:0]            o_zero_cross_input,
    output logic [2:0][DW-1:0]       o_apparent_voltage,
    output logic [2:0][2:0]          o_multipoint_gain_factor,
    output logic [DW+1:0]            o_summed_current
);

    logic [11:0] addr;
    logic        wr;
    logic [31:0] wdata;
    logic        rd;
    logic [31:0] rdata_q;
    logic [31:0] config_q;
    logic [31:0] copy_q [MDC_NUM_COPIES];
    logic [DW+1:0] sum_d;

    // Index of a result copy from a word address, or -1 when outside the block
    function automatic int copy_index(input logic [11:0] a);
        if (a >= MDC_ADDR_C_IRMS_LNG && a <= MDC_ADDR_N_IRMS_LNG) begin
            return int'(a - MDC_ADDR_C_IRMS_LNG);
        end
        return -1;
    endfunction : copy_index

    // Sign extension to the summed-current width
    function automatic logic [DW+1:0] sx(input logic [DW-1:0] v);
        return {{2{v[DW-1]}}, v};
    endfunction : sx

    mdc_spi_link u_link (
        .i_clock    (i_clock),
        .i_nrst     (i_nrst),
        .i_spi_sclk (i_spi_sclk),
        .i_spi_cs_n (i_spi_cs_n),
        .i_spi_mosi (i_spi_mosi),
        .o_spi_miso (o_spi_miso),
        .o_addr     (addr),
        .o_wr       (wr),
        .o_wdata    (wdata),
        .o_rd       (rd),
        .i_rdata    (rdata_q)
    );

    // Configuration word: only writable bits are stored
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            config_q <= MDC_CONFIG_RESET;
        end else if (wr && addr == MDC_ADDR_CONFIG) begin
            config_q <= wdata & MDC_CONFIG_WMASK;
        end
    end

    // Result copies: core update wins over a host write in the same cycle
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int k = 0; k < MDC_NUM_COPIES; k++) begin
                copy_q[k] <= MDC_COPY_RESET;
            end
        end else if (i_result_update) begin
            for (int k = 0; k < MDC_NUM_COPIES; k++) begin
                copy_q[k] <= i_result_copy_value[k];
            end
        end else if (wr && copy_index(addr) >= 0) begin
            copy_q[copy_index(addr)] <= wdata;
        end
    end

    // Read data, fetched one cycle after the link asks; unmapped reads zero
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd) begin
            if (addr == MDC_ADDR_CONFIG) begin
                rdata_q <= config_q & MDC_CONFIG_WMASK;
            end else if (copy_index(addr) >= 0) begin
                rdata_q <= copy_q[copy_index(addr)];
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    // Filter, integrator and multipoint controls straight from the stored word
    assign o_reactive_lowpass_bypass = config_q[MDC_BIT_REACT_LPF_BYP];
    assign o_active_lowpass_bypass   = config_q[MDC_BIT_ACT_LPF_BYP];
    assign o_neutral_integrator_on   = config_q[MDC_BIT_NEUT_INTEG];
    assign o_phase_integrator_on     = config_q[MDC_BIT_PHASE_INTEG];
    assign o_multipoint_comp_on      = config_q[MDC_BIT_MULTIPOINT];
    assign o_highpass_bypass_all     = config_q[MDC_BIT_HPF_BYP];

    // Source selection for rms and zero-cross paths
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rms_input        <= '0;
            o_zero_cross_input <= '0;
        end else begin
            o_rms_input        <= config_q[MDC_BIT_RMS_SEL] ? i_rms_raw_sample
                                                            : i_rms_filtered_sample;
            o_zero_cross_input <= config_q[MDC_BIT_ZX_SEL] ? i_zero_cross_before_filters
                                                           : i_zero_cross_after_filters;
        end
    end

    // Voltage used for each phase's apparent power
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_apparent_voltage <= '0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                o_apparent_voltage[p] <= config_q[MDC_BIT_NOM_V_A + p] ? i_nominal_voltage_value
                                                                       : i_phase_voltage_rms[p];
            end
        end
    end

    // Summed current formula
    always_comb begin
        sum_d = sx(i_phase_a_current_waveform) + sx(i_phase_b_current_waveform)
              + sx(i_phase_c_current_waveform);
        case (mdc_sum_t'(config_q[MDC_BIT_SUM_LO +: 2]))
            MDC_SUM_PLUS_N:  sum_d = sum_d + sx(i_neutral_current_waveform);
            MDC_SUM_MINUS_N: sum_d = sum_d - sx(i_neutral_current_waveform);
            default:         sum_d = sum_d;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_summed_current <= '0;
        end else begin
            o_summed_current <= sum_d;
        end
    end

    // Multipoint region per phase: step up past a high threshold, down below a low one
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_multipoint_gain_factor <= '0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (!config_q[MDC_BIT_MULTIPOINT]) begin
                    o_multipoint_gain_factor[p] <= 3'h0;
                end else if (o_multipoint_gain_factor[p] < MDC_MT_TOP &&
                             i_phase_current_rms[p] >
                             i_multipoint_high_threshold[o_multipoint_gain_factor[p]]) begin
                    o_multipoint_gain_factor[p] <= o_multipoint_gain_factor[p] + 3'h1;
                end else if (o_multipoint_gain_factor[p] > 3'h0 &&
                             i_phase_current_rms[p] <
                             i_multipoint_low_threshold[o_multipoint_gain_factor[p] - 3'h1]) begin
                    o_multipoint_gain_factor[p] <= o_multipoint_gain_factor[p] - 3'h1;
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    // Write strobe to the configuration word, one cycle late
    logic cfg_wr_q;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_wr_q <= 1'b0;
        end else begin
            cfg_wr_q <= wr && addr == MDC_ADDR_CONFIG;
        end
    end

    sequence cfg_write_s;
        wr && addr == MDC_ADDR_CONFIG;
    endsequence

    sequence cfg_read_s;
        rd && addr == MDC_ADDR_CONFIG;
    endsequence

    sequence mt_climb_s;
        config_q[4] && o_multipoint_gain_factor[1] < MDC_MT_TOP &&
        i_phase_current_rms[1] > i_multipoint_high_threshold[o_multipoint_gain_factor[1]];
    endsequence

    sequence copy_host_write_s;
        wr && !i_result_update && addr == MDC_ADDR_N_IRMS_LNG;
    endsequence

    // Configuration storage and the controls it drives
    cfg_reserved_a: assert property ((config_q & ~MDC_CONFIG_WMASK) == 32'h0)
        else $error("reserved configuration bits are not zero");
    cfg_write_a: assert property (cfg_write_s |=> config_q == ($past(wdata) & MDC_CONFIG_WMASK))
        else $error("configuration write stored wrong value");
    cfg_readback_a: assert property (cfg_read_s ##0 (!wr)[*1] |=> rdata_q[31:14] == 18'h0 && !rdata_q[2])
        else $error("reserved bits read back non-zero");
    lpf_bypass_a: assert property ($rose(config_q[13]) |-> o_reactive_lowpass_bypass && cfg_wr_q)
        else $error("reactive bypass changed without a write");
    lpf_clear_a: assert property ($fell(config_q[13]) |-> !o_reactive_lowpass_bypass && cfg_wr_q)
        else $error("reactive bypass cleared without a write");
    act_bypass_a: assert property (o_active_lowpass_bypass == config_q[12] &&
        o_highpass_bypass_all == config_q[3])
        else $error("active or high-pass bypass mismatch");
    act_change_a: assert property ($changed(o_active_lowpass_bypass) |->
        cfg_wr_q && $past(wdata[12]) == o_active_lowpass_bypass)
        else $error("active bypass changed wrongly");
    hpf_change_a: assert property ($changed(o_highpass_bypass_all) |->
        cfg_wr_q && $past(wdata[3]) == o_highpass_bypass_all)
        else $error("high-pass bypass changed wrongly");
    integ_split_a: assert property ($changed(o_phase_integrator_on) |->
        cfg_wr_q && $past(wdata[5]) == o_phase_integrator_on)
        else $error("phase integrator changed wrongly");
    neut_integ_a: assert property ($changed(o_neutral_integrator_on) |->
        $past(wdata[11]) == o_neutral_integrator_on)
        else $error("neutral integrator changed wrongly");
    mp_change_a: assert property ($changed(o_multipoint_comp_on) |->
        cfg_wr_q && $past(wdata[4]) == o_multipoint_comp_on)
        else $error("multipoint enable changed wrongly");

    // Datapath selects
    zx_source_a: assert property (config_q[6] && $stable(config_q) |=>
        o_zero_cross_input == $past(i_zero_cross_before_filters))
        else $error("zero-cross source wrong");
    zx_after_a: assert property (!config_q[6] |=> o_zero_cross_input == $past(i_zero_cross_after_filters))
        else $error("zero-cross after source wrong");
    rms_source_a: assert property (!config_q[7] && $stable(config_q) |=>
        o_rms_input == $past(i_rms_filtered_sample))
        else $error("rms source wrong");
    rms_raw_a: assert property (config_q[7] |=> o_rms_input == $past(i_rms_raw_sample))
        else $error("rms raw source wrong");
    nominal_c_a: assert property (config_q[10] && $stable(config_q) |=>
        o_apparent_voltage[2] == $past(i_nominal_voltage_value))
        else $error("phase C apparent voltage wrong");
    nominal_a_a: assert property (config_q[8] |=> o_apparent_voltage[0] == $past(i_nominal_voltage_value))
        else $error("phase A apparent voltage wrong");
    measured_b_a: assert property (!config_q[9] |=> o_apparent_voltage[1] == $past(i_phase_voltage_rms[1]))
        else $error("phase B measured voltage wrong");
    sum_minus_a: assert property (config_q[1:0] == 2'h2 && $stable(config_q) |=>
        o_summed_current == $past(sx(i_phase_a_current_waveform) + sx(i_phase_b_current_waveform)
                                  + sx(i_phase_c_current_waveform) - sx(i_neutral_current_waveform)))
        else $error("summed current minus neutral wrong");
    sum_plus_a: assert property (config_q[1:0] == 2'h1 |=>
        o_summed_current == $past(sx(i_phase_a_current_waveform) + sx(i_phase_b_current_waveform)
                                  + sx(i_phase_c_current_waveform) + sx(i_neutral_current_waveform)))
        else $error("summed current plus neutral wrong");

    // Multipoint region and result copies
    mt_off_a: assert property (!config_q[4] |=> o_multipoint_gain_factor == '0)
        else $error("gain index not cleared while disabled");
    mt_climb_a: assert property (mt_climb_s |=>
        o_multipoint_gain_factor[1] == $past(o_multipoint_gain_factor[1]) + 3'h1)
        else $error("gain index did not step up");
    mt_range_a: assert property (o_multipoint_gain_factor[0] <= MDC_MT_TOP &&
        o_multipoint_gain_factor[2] <= MDC_MT_TOP)
        else $error("gain index out of range");
    copy_update_a: assert property (i_result_update |=> copy_q[5] == $past(i_result_copy_value[5]))
        else $error("neutral long rms copy not updated");
    copy_write_a: assert property (copy_host_write_s |=> copy_q[5] == $past(wdata))
        else $error("neutral long rms copy not written");
    copy_read_a: assert property (rd && addr == MDC_ADDR_C_IRMS_LNG |=> rdata_q == $past(copy_q[0]))
        else $error("phase C current copy read wrong");

endmodule : mdc_top

// >>> bench/mdc_host_model.sv
// Serial host model: mode 0 frames, a 16-bit command then 32-bit words, MSB first.
// Assumes the device samples its pins on i_clock; half sets each sclk phase in cycles.
`timescale 1ns/10ps
module mdc_host_model #(
    parameter int HALF = 6
)(
    input  wire logic i_clock,
    output logic      o_spi_sclk,
    output logic      o_spi_cs_n,
    output logic      o_spi_mosi,
    input  wire logic i_spi_miso
);
    logic [31:0] word_buf [6];
    int          half = HALF;

    // Idle: clock stands low, device deselected
    initial begin
        o_spi_sclk = 1'b0;
        o_spi_cs_n = 1'b1;
        o_spi_mosi = 1'b1;
    end

    // One bit: data set while low, both sides take it at the rise
    task automatic shift(input logic bit_out, output logic bit_in);
        o_spi_mosi <= bit_out;
        repeat (half) @(posedge i_clock);
        bit_in = i_spi_miso;
        o_spi_sclk <= 1'b1;
        repeat (half) @(posedge i_clock);
        o_spi_sclk <= 1'b0;
    endtask : shift

    // Whole frame; read words land in word_buf, write words come from it
    task automatic xfer(input logic [11:0] addr, input logic rd, input int n);
        logic [15:0] cmd;
        logic        b;
        cmd = {addr, rd, 3'h0};
        repeat (half) @(posedge i_clock);
        o_spi_cs_n <= 1'b0;
        repeat (half) @(posedge i_clock);
        for (int i = 15; i >= 0; i--) shift(cmd[i], b);
        for (int w = 0; w < n; w++) begin
            for (int i = 31; i >= 0; i--) begin
                shift(word_buf[w][i], b);
                if (rd) word_buf[w][i] = b;
            end
        end
        repeat (half) @(posedge i_clock);
        o_spi_cs_n <= 1'b1;
        o_spi_mosi <= ~o_spi_mosi;  // Released line does not keep its value
    endtask : xfer
endmodule : mdc_host_model

// >>> bench/testbench.sv
// Self-checking bench: configuration word, datapath selects and result copies.
// Assumes the host model speaks the serial port and a 125 MHz core clock.
`timescale 1ns/10ps
module testbench
    import mdc_pkg::*;
;
    logic             clock, nrst, sclk, cs_n, mosi, miso, update;
    logic             react_byp, act_byp, neut_int, phase_int, mp_on, hpf_byp;
    logic [31:0]      wave_a, wave_b, wave_c, wave_n, rms_filt, rms_raw, zx_after, zx_before, nominal, rms_in, zx_in;
    logic [2:0][31:0] volt_rms, curr_rms, app_v;
    logic [4:0][31:0] thr_lo, thr_hi;
    logic [5:0][31:0] copy_val;
    logic [2:0][2:0]  mp_gain;
    logic [33:0]      sum_cur, exp_sum;
    logic [31:0]      cfg;
    logic [31:0]      cfg_tab [13] = '{32'hFFFFFFFF, 32'h2000, 32'h1000, 32'h0800, 32'h0020, 32'h0010,
                                       32'h0008, 32'h0580, 32'h0240, 32'h0001, 32'h0002, 32'h0003, 32'h0004};
    int               failures = 0;
    int               total_checks = 0;

    mdc_host_model host_inst (.i_clock(clock), .o_spi_sclk(sclk), .o_spi_cs_n(cs_n), .o_spi_mosi(mosi),
                              .i_spi_miso(miso));
    mdc_top mdc_top_inst (.i_clock(clock), .i_nrst(nrst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .i_phase_a_current_waveform(wave_a),
        .i_phase_b_current_waveform(wave_b), .i_phase_c_current_waveform(wave_c),
        .i_neutral_current_waveform(wave_n), .i_rms_filtered_sample(rms_filt), .i_rms_raw_sample(rms_raw),
        .i_zero_cross_after_filters(zx_after), .i_zero_cross_before_filters(zx_before),
        .i_nominal_voltage_value(nominal), .i_phase_voltage_rms(volt_rms), .i_phase_current_rms(curr_rms),
        .i_multipoint_low_threshold(thr_lo), .i_multipoint_high_threshold(thr_hi), .i_result_update(update),
        .i_result_copy_value(copy_val), .o_reactive_lowpass_bypass(react_byp), .o_active_lowpass_bypass(act_byp),
        .o_neutral_integrator_on(neut_int), .o_phase_integrator_on(phase_int), .o_multipoint_comp_on(mp_on),
        .o_highpass_bypass_all(hpf_byp), .o_rms_input(rms_in), .o_zero_cross_input(zx_in),
        .o_apparent_voltage(app_v), .o_multipoint_gain_factor(mp_gain), .o_summed_current(sum_cur));

    // Free-running core clock
    initial clock = 1'b0;
    always #4 clock = ~clock;

    // Compare and count
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        host_inst.word_buf[0] = data;
        host_inst.xfer(addr, 1'b0, 1);
        repeat (4) @(posedge clock);
    endtask : wr

    task automatic rd(input logic [11:0] addr, input int n);
        host_inst.xfer(addr, 1'b1, n);
    endtask : rd

    task automatic end_of_test;
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // Cut a hang short
    initial begin
        repeat (80000) @(posedge clock);
        failures++;
        end_of_test();
    end

    // Main sequence
    initial begin
        nrst = 1'b0; update = 1'b0;
        wave_a = 32'h10; wave_b = 32'h20; wave_c = 32'h30; wave_n = 32'h08;
        rms_filt = 32'hAAAA0001; rms_raw = 32'h5555FFFE; zx_after = 32'h11110000; zx_before = 32'h0000EEEE;
        nominal = 32'h0C0FFEE0; curr_rms = '0;
        for (int k = 0; k < 3; k++) volt_rms[k] = 32'h100 + k;
        for (int k = 0; k < 5; k++) thr_hi[k] = 32'h100 * (k + 1);
        for (int k = 0; k < 5; k++) thr_lo[k] = 32'h100 * (k + 1) - 32'h80;
        for (int k = 0; k < 6; k++) copy_val[k] = 32'hC0DE0000 + k;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        check("react_byp", react_byp, 1'b0);
        rd(MDC_ADDR_CONFIG, 1);
        check("config", host_inst.word_buf[0], MDC_CONFIG_RESET);
        host_inst.half = 11;
        rd(MDC_ADDR_C_IRMS_LNG, 6);
        for (int k = 0; k < 6; k++) check("copy", host_inst.word_buf[k], MDC_COPY_RESET);
        host_inst.half = 6;
        // Every field, reserved bits and formula codes
        for (int t = 0; t < 13; t++) begin
            cfg = cfg_tab[t];
            wr(MDC_ADDR_CONFIG, cfg);
            rd(MDC_ADDR_CONFIG, 1);
            check("config", host_inst.word_buf[0], cfg & MDC_CONFIG_WMASK);
            check("react_byp", react_byp, cfg[13]);
            check("act_byp", act_byp, cfg[12]);
            check("neut_int", neut_int, cfg[11]);
            check("phase_int", phase_int, cfg[5]);
            check("mp_on", mp_on, cfg[4]);
            check("hpf_byp", hpf_byp, cfg[3]);
            check("rms_in", rms_in, cfg[7] ? rms_raw : rms_filt);
            check("zx_in", zx_in, cfg[6] ? zx_before : zx_after);
            for (int k = 0; k < 3; k++) check("app_v", app_v[k], cfg[8 + k] ? nominal : volt_rms[k]);
            exp_sum = 34'($signed(wave_a)) + 34'($signed(wave_b)) + 34'($signed(wave_c));
            if (cfg[1:0] == 2'h1) exp_sum = exp_sum + 34'($signed(wave_n));
            if (cfg[1:0] == 2'h2) exp_sum = exp_sum - 34'($signed(wave_n));
            check("sum_cur", sum_cur, exp_sum);
        end
        // Region climbs to the top, falls back with hysteresis, clears when disabled
        wr(MDC_ADDR_CONFIG, 32'h0010);
        curr_rms[1] <= 32'h1000;
        repeat (12) @(posedge clock);
        check("mp_gain1", mp_gain[1], MDC_MT_TOP);
        check("mp_gain0", mp_gain[0], 3'h0);
        curr_rms[1] <= 32'h150;
        repeat (12) @(posedge clock);
        check("mp_gain1", mp_gain[1], 3'h1);
        wr(MDC_ADDR_CONFIG, 32'h0000);
        check("mp_gain1", mp_gain[1], 3'h0);
        // Copies load from the core, then by burst write
        update <= 1'b1;
        @(posedge clock);
        update <= 1'b0;
        host_inst.half = 5;
        rd(MDC_ADDR_C_IRMS_LNG, 6);
        for (int k = 0; k < 6; k++) check("copy", host_inst.word_buf[k], 32'hC0DE0000 + k);
        host_inst.half = 6;
        for (int k = 0; k < 6; k++) host_inst.word_buf[k] = 32'h600D0000 + k;
        host_inst.xfer(MDC_ADDR_C_IRMS_LNG, 1'b0, 6);
        rd(MDC_ADDR_C_IRMS_LNG, 6);
        for (int k = 0; k < 6; k++) check("copy", host_inst.word_buf[k], 32'h600D0000 + k);
        rd(12'h123, 1);
        check("unmapped", host_inst.word_buf[0], 32'h0);
        end_of_test();
    end
endmodule : testbench
